// ---- rtl/dbw_params.svh ----
// Constants for the DDR byte-lane write masking block.
// Assumes it is included by bare name from the package and the design files.
`ifndef DBW_PARAMS_SVH
`define DBW_PARAMS_SVH

// Register byte offsets on the APB side.
`define DBW_CTRL_OFS 12'h000
`define DBW_STAT_OFS 12'h004
`define DBW_ADDR_W 12

// Control register fields and reset values.
`define DBW_CTRL_EN_BIT 0
`define DBW_CTRL_WIDE_BIT 1
`define DBW_CTRL_RST 32'h0000_0000

// Array and data organisation.
`define DBW_DATA_W 36
`define DBW_LANE_W 9
`define DBW_LANES 4
`define DBW_NARROW_LANES 2
`define DBW_MEM_AW 4
`define DBW_MEM_DEPTH 16
`define DBW_CNT_W 8

`endif

// ---- rtl/dbw_pkg.sv ----
// Types shared by the DDR byte-lane write masking block.
// Assumes the constants header sits beside it.
`include "dbw_params.svh"

package dbw_pkg;

  // Link-side sequencer states, one-hot coded.
  typedef enum logic [1:0] {
    DBW_IDLE = 2'b01,
    DBW_DATA = 2'b10
  } dbw_state_t;

  typedef logic [`DBW_DATA_W-1:0] dbw_word_t;
  typedef logic [`DBW_LANES-1:0] dbw_sel_t;

endpackage

// ---- rtl/dbw_sync2.sv ----
// Two-flop level synchroniser of parameterised width.
// Assumes each bit is a slow level or a gray-coded bus that moves one bit at a time.
module dbw_sync2 #(
  parameter int W = 1
) (
  // Destination clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Level crossing.
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;

  // The first stage feeds only the second, so metastability settles before use.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule

// ---- rtl/dbw_top.sv ----
// Byte-lane masked write path of a two-word-burst DDR SRAM, with APB control.
// Assumes a memory controller drives the link pins on link_clk, and an APB master on pclk.
//
// Register access over APB and the register offsets were chosen for this implementation.
`include "dbw_params.svh"

module dbw_top
  import dbw_pkg::*;
(
  // APB clock, reset and clock enable.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`DBW_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Link clock and command pins.
  input wire logic link_clk,
  input wire logic load_strobe_n,
  input wire logic rd_wr_n,
  input wire logic [`DBW_MEM_AW-1:0] link_addr,
  // Link write data and byte lane selects.
  input wire logic [`DBW_DATA_W-1:0] wr_data,
  input wire logic byte_lane_sel_0_n,
  input wire logic byte_lane_sel_1_n,
  input wire logic byte_lane_sel_2_n,
  input wire logic byte_lane_sel_3_n,
  // Array inspection port on the link clock.
  input wire logic [`DBW_MEM_AW-1:0] peek_addr,
  output logic [`DBW_DATA_W-1:0] peek_data
);

  // lane masking
  // Merge a beat into a stored word, lane by lane; narrow mode ignores upper lanes.
  function automatic dbw_word_t dbw_merge(input dbw_word_t old_w, input dbw_word_t new_w,
                                          input dbw_sel_t sel_n, input logic wide);
    dbw_word_t res;
    res = old_w;
    for (int l = 0; l < `DBW_LANES; l++) begin
      if (!sel_n[l] && (wide || l < `DBW_NARROW_LANES)) begin
        res[l*`DBW_LANE_W +: `DBW_LANE_W] = new_w[l*`DBW_LANE_W +: `DBW_LANE_W];
      end
    end
    return res;
  endfunction

  // Address decode, used by both the read mux and the error answer.
  function automatic logic dbw_is_mapped(input logic [`DBW_ADDR_W-1:0] a);
    return (a == `DBW_CTRL_OFS) || (a == `DBW_STAT_OFS);
  endfunction

  // Gray to binary conversion for the crossed write counter.
  function automatic logic [`DBW_CNT_W-1:0] dbw_gray2bin(input logic [`DBW_CNT_W-1:0] g);
    logic [`DBW_CNT_W-1:0] b;
    b = '0;
    b[`DBW_CNT_W-1] = g[`DBW_CNT_W-1];
    for (int i = `DBW_CNT_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  // Control reset image; each field takes its own bit, so no reset value is truncated.
  localparam logic [31:0] ctrl_rst_v = `DBW_CTRL_RST;

  logic en_r;
  logic wide_r;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic [`DBW_CNT_W-1:0] gray_p;
  logic [`DBW_CNT_W-1:0] wcnt_p;
  logic lrst_meta_r;
  logic lrst_n;
  logic en_l;
  logic wide_l;
  logic ce_l;
  dbw_state_t state_r;
  dbw_state_t state_nxt;
  logic [`DBW_MEM_AW-1:0] cmd_addr_r;
  logic b2_pend_r;
  logic [`DBW_MEM_AW-1:0] b2_addr_r;
  dbw_word_t hi_data_r;
  dbw_sel_t hi_sel_r;
  dbw_sel_t lo_sel;
  logic cmd_go;
  logic b1_go;
  logic [`DBW_CNT_W-1:0] wcnt_r;
  logic [`DBW_CNT_W-1:0] gray_r;
  logic [`DBW_MEM_DEPTH-1:0][`DBW_DATA_W-1:0] mem_r;
  logic [`DBW_MEM_DEPTH-1:0][`DBW_DATA_W-1:0] mem_nxt;
  logic [`DBW_DATA_W-1:0] peek_r;

  // APB answers come straight from flops.
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign peek_data = peek_r;

  // APB answer: one wait state, then pready high for exactly one edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else if (ce) begin
      if (psel && penable && !pready_r) begin
        pready_r <= 1'b1;
        pslverr_r <= !dbw_is_mapped(paddr);
        if (pwrite || !dbw_is_mapped(paddr)) begin
          prdata_r <= 32'h0000_0000;
        end else if (paddr == `DBW_CTRL_OFS) begin
          prdata_r <= {{30{1'b0}}, wide_r, en_r};
        end else begin
          prdata_r <= {24'h00_0000, wcnt_p};
        end
      end else begin
        pready_r <= 1'b0;
        pslverr_r <= 1'b0;
      end
    end
  end

  // Control register; the write lands on the edge that samples pready high.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_r <= ctrl_rst_v[`DBW_CTRL_EN_BIT];
      wide_r <= ctrl_rst_v[`DBW_CTRL_WIDE_BIT];
    end else if (ce && psel && penable && pready_r && pwrite && paddr == `DBW_CTRL_OFS) begin
      en_r <= pwdata[`DBW_CTRL_EN_BIT];
      wide_r <= pwdata[`DBW_CTRL_WIDE_BIT];
    end
  end

  // Write-command counter crosses to pclk as gray code, one bit moving per step.
  dbw_sync2 #(.W(`DBW_CNT_W)) u_cnt_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d(gray_r),
    .q(gray_p)
  );

  assign wcnt_p = dbw_gray2bin(gray_p);

  // Link reset asserts at once and releases on link_clk, so link flops leave reset cleanly.
  always_ff @(posedge link_clk or negedge presetn) begin
    if (!presetn) begin
      lrst_meta_r <= 1'b0;
      lrst_n <= 1'b0;
    end else begin
      lrst_meta_r <= 1'b1;
      lrst_n <= lrst_meta_r;
    end
  end

  // Control levels and the clock enable cross into the link domain.
  dbw_sync2 #(.W(3)) u_ctrl_sync (
    .clk(link_clk),
    .rst_n(lrst_n),
    .d({ce, wide_r, en_r}),
    .q({ce_l, wide_l, en_l})
  );

  assign lo_sel = {byte_lane_sel_3_n, byte_lane_sel_2_n, byte_lane_sel_1_n, byte_lane_sel_0_n};
  // load decode
  // A write starts only on load low with read/write low at a true-clock edge.
  assign cmd_go = en_l && !load_strobe_n && !rd_wr_n;
  // write gating
  // The first beat is written only in the cycle after an accepted write command.
  assign b1_go = (state_r == DBW_DATA);

  // Sequencer: a new write may be loaded every cycle, overlapping the previous beats.
  always_comb begin
    case (state_r)
      DBW_IDLE: state_nxt = cmd_go ? DBW_DATA : DBW_IDLE;
      DBW_DATA: state_nxt = cmd_go ? DBW_DATA : DBW_IDLE;
      default: state_nxt = DBW_IDLE;
    endcase
  end

  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      state_r <= DBW_IDLE;
      cmd_addr_r <= '0;
    end else if (ce_l) begin
      state_r <= state_nxt;
      if (cmd_go) begin
        cmd_addr_r <= link_addr;
      end
    end
  end

  // burst address
  // The second beat goes to the loaded address with its low bit inverted.
  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      b2_pend_r <= 1'b0;
      b2_addr_r <= '0;
    end else if (ce_l) begin
      b2_pend_r <= b1_go;
      b2_addr_r <= cmd_addr_r ^ {{(`DBW_MEM_AW-1){1'b0}}, 1'b1};
    end
  end

  // complement beat
  // The second beat and its own mask are caught on the complement edge.
  always_ff @(negedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      hi_data_r <= '0;
      hi_sel_r <= '1;
    end else if (ce_l) begin
      hi_data_r <= wr_data;
      hi_sel_r <= lo_sel;
    end
  end

  // lane merge
  // The older second beat is applied first, so a newer first beat on the same word wins.
  generate
    for (genvar i = 0; i < `DBW_MEM_DEPTH; i++) begin : g_word
      always_comb begin
        mem_nxt[i] = mem_r[i];
        if (b2_pend_r && b2_addr_r == i[`DBW_MEM_AW-1:0]) begin
          mem_nxt[i] = dbw_merge(mem_nxt[i], hi_data_r, hi_sel_r, wide_l);
        end
        if (b1_go && cmd_addr_r == i[`DBW_MEM_AW-1:0]) begin
          mem_nxt[i] = dbw_merge(mem_nxt[i], wr_data, lo_sel, wide_l);
        end
      end
    end
  endgenerate

  // Array, counter and inspection read, all on the true clock.
  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      mem_r <= '0;
    end else if (ce_l) begin
      mem_r <= mem_nxt;
    end
  end

  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      wcnt_r <= '0;
      gray_r <= '0;
      peek_r <= '0;
    end else if (ce_l) begin
      wcnt_r <= wcnt_r + {{(`DBW_CNT_W-1){1'b0}}, cmd_go};
      gray_r <= wcnt_r ^ (wcnt_r >> 1);
      peek_r <= mem_r[peek_addr];
    end
  end

  // Helpers for the checks: beats whose word is not also hit by the other beat.
  logic b1_solo;
  logic b2_solo;
  logic [`DBW_DATA_W-1:0] b1_old;
  logic [`DBW_DATA_W-1:0] b2_old;
  assign b1_solo = b1_go && !(b2_pend_r && b2_addr_r == cmd_addr_r);
  assign b2_solo = b2_pend_r && !(b1_go && b2_addr_r == cmd_addr_r);
  assign b1_old = mem_r[cmd_addr_r];
  assign b2_old = mem_r[b2_addr_r];

  sequence s_write_cmd;
    cmd_go;
  endsequence

  sequence s_burst_beats(logic [`DBW_MEM_AW-1:0] a);
    b1_go && cmd_addr_r == a ##1 b2_pend_r && b2_addr_r == (a ^ 4'h1);
  endsequence

  property p_burst_addr;
    logic [`DBW_MEM_AW-1:0] a;
    @(posedge link_clk) disable iff (!lrst_n || !ce_l)
      (s_write_cmd, a = link_addr) |=> s_burst_beats(a);
  endproperty

  chk_burst_addr: assert property (p_burst_addr)
    else $error("second beat not aimed at the inverted-low-bit address");

  chk_narrow_lane0: assert property (@(posedge link_clk) disable iff (!lrst_n || !ce_l)
    b1_solo && !wide_l && !byte_lane_sel_0_n
      |=> mem_r[$past(cmd_addr_r)][8:0] == $past(wr_data[8:0]))
    else $error("narrow lane 0 not written");

  chk_narrow_upper: assert property (@(posedge link_clk) disable iff (!lrst_n || !ce_l)
    b1_solo && !wide_l
      |=> mem_r[$past(cmd_addr_r)][35:18] == $past(b1_old[35:18]))
    else $error("narrow write touched the upper lanes");

  chk_narrow_hold: assert property (@(posedge link_clk) disable iff (!lrst_n || !ce_l)
    b1_solo && !wide_l && byte_lane_sel_0_n && byte_lane_sel_1_n
      |=> mem_r[$past(cmd_addr_r)] == $past(b1_old))
    else $error("narrow word changed with both selects high");

  chk_wide_lane3: assert property (@(posedge link_clk) disable iff (!lrst_n || !ce_l)
    b1_solo && wide_l && !byte_lane_sel_3_n
      |=> mem_r[$past(cmd_addr_r)][35:27] == $past(wr_data[35:27]))
    else $error("wide lane 3 not written");

  chk_wide_full: assert property (@(posedge link_clk) disable iff (!lrst_n || !ce_l)
    b1_solo && wide_l && lo_sel == 4'h0
      |=> mem_r[$past(cmd_addr_r)] == $past(wr_data))
    else $error("wide word not fully written");

  chk_wide_hold: assert property (@(posedge link_clk) disable iff (!lrst_n || !ce_l)
    b1_solo && wide_l && lo_sel == 4'hF
      |=> mem_r[$past(cmd_addr_r)] == $past(b1_old))
    else $error("wide word changed with all selects high");

  chk_hi_beat_mask: assert property (@(posedge link_clk) disable iff (!lrst_n || !ce_l)
    b2_solo && wide_l && hi_sel_r == 4'hF
      |=> mem_r[$past(b2_addr_r)] == $past(b2_old))
    else $error("second beat ignored its own mask");

  chk_hi_beat_lane0: assert property (@(posedge link_clk) disable iff (!lrst_n || !ce_l)
    b2_solo && !hi_sel_r[0]
      |=> mem_r[$past(b2_addr_r)][8:0] == $past(hi_data_r[8:0]))
    else $error("second beat lane 0 not written");

  chk_idle_stable: assert property (@(posedge link_clk) disable iff (!lrst_n || !ce_l)
    state_r == DBW_IDLE && !b2_pend_r |=> $stable(mem_r))
    else $error("array changed outside a write");

  chk_mixed_lane1: assert property (@(posedge link_clk) disable iff (!lrst_n || !ce_l)
    b1_solo && byte_lane_sel_1_n && !byte_lane_sel_0_n
      |=> mem_r[$past(cmd_addr_r)][17:9] == $past(b1_old[17:9]))
    else $error("lane 1 altered while its select was high");

endmodule

// ---- dv/dbw_ctl_model.sv ----
// Memory controller model driving the link pins of the masked write path.
// Assumes a free-running link clock; the bench calls the burst task.
`include "dbw_params.svh"

module dbw_ctl_model
  import dbw_pkg::*;
(
  // Link clock.
  input wire logic link_clk,
  // Command, data and lane selects.
  output logic load_strobe_n,
  output logic rd_wr_n,
  output logic [`DBW_MEM_AW-1:0] link_addr,
  output dbw_word_t wr_data,
  output dbw_sel_t sel_n
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle levels at time zero.
  initial begin
    load_strobe_n = 1'b1;
    rd_wr_n = 1'b1;
    link_addr = '0;
    wr_data = '0;
    sel_n = '1;
  end

  task automatic burst(input logic rw, input logic [3:0] a, input dbw_word_t d1, d2,
                       input dbw_sel_t m1, m2);
    @(posedge link_clk);
    load_strobe_n <= 1'b0;
    rd_wr_n <= rw;
    link_addr <= a;
    @(posedge link_clk);
    load_strobe_n <= 1'b1;
    rd_wr_n <= ~rw;
    link_addr <= ~a;
    wr_data <= d1;
    sel_n <= m1;
    @(posedge link_clk);
    wr_data <= d2;
    sel_n <= m2;
    @(negedge link_clk);
    // Released lines carry the inverse, so stale values never pass.
    wr_data <= ~d2;
    sel_n <= ~m2;
  endtask
endmodule

// ---- dv/tb_top.sv ----
// Self-checking bench: APB control plus random masked link bursts.
// Assumes the array is observed through the peek port only.
`include "dbw_params.svh"

module tb_top
  import dbw_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;

  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic ce = 1'b1;
  logic [`DBW_ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, err, link_clk, load_strobe_n, rd_wr_n, wide;
  logic [`DBW_MEM_AW-1:0] link_addr, peek_addr = '0;
  dbw_word_t wr_data, peek_data, exp_mem [16];
  dbw_sel_t sel_n;
  dbw_sel_t corner [8] = '{4'h0, 4'hF, 4'hE, 4'hD, 4'hB, 4'h7, 4'h5, 4'hA};
  int num_errors = 0, total_checks = 0, wcount = 0;

  // Bus clock, and a link clock offset so the two never line up.
  always #20 pclk = ~pclk;
  initial begin
    link_clk = 1'b0;
    #13;
    forever #80 link_clk = ~link_clk;
  end

  dbw_top DUT (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link_clk(link_clk), .load_strobe_n(load_strobe_n),
    .rd_wr_n(rd_wr_n), .link_addr(link_addr), .wr_data(wr_data),
    .byte_lane_sel_0_n(sel_n[0]), .byte_lane_sel_1_n(sel_n[1]),
    .byte_lane_sel_2_n(sel_n[2]), .byte_lane_sel_3_n(sel_n[3]),
    .peek_addr(peek_addr), .peek_data(peek_data));

  dbw_ctl_model ctl (.link_clk(link_clk), .load_strobe_n(load_strobe_n),
    .rd_wr_n(rd_wr_n), .link_addr(link_addr), .wr_data(wr_data), .sel_n(sel_n));

  // Lane-by-lane merge; narrow mode leaves the upper lanes alone.
  function automatic dbw_word_t merge(dbw_word_t old, dbw_word_t d, dbw_sel_t m, logic w);
    dbw_word_t r;
    r = old;
    for (int i = 0; i < `DBW_LANES; i++)
      if (!m[i] && (w || i < `DBW_NARROW_LANES))
        r[i*`DBW_LANE_W +: `DBW_LANE_W] = d[i*`DBW_LANE_W +: `DBW_LANE_W];
    return r;
  endfunction

  task automatic wrap_up();
    $display("Checks made: %0d, mismatches: %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input logic [35:0] seen, exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // One APB transfer; the wait for pready is bounded.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      num_errors++;
      wrap_up();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic peek_chk(input logic [3:0] ad);
    @(posedge link_clk);
    peek_addr <= ad;
    repeat (2) @(posedge link_clk);
    @(negedge link_clk);
    check(peek_data, exp_mem[ad], "array word");
  endtask

  // Run one burst, update the expected array, then look at both words.
  task automatic burst_chk(input logic rw, input logic [3:0] ad, input dbw_word_t x1, x2,
                           input dbw_sel_t s1, s2, input logic en);
    ctl.burst(rw, ad, x1, x2, s1, s2);
    if (en && !rw) begin
      exp_mem[ad] = merge(exp_mem[ad], x1, s1, wide);
      exp_mem[ad ^ 4'h1] = merge(exp_mem[ad ^ 4'h1], x2, s2, wide);
      wcount++;
    end
    peek_chk(ad);
    peek_chk(ad ^ 4'h1);
  endtask

  function automatic dbw_word_t rw36();
    return dbw_word_t'({$urandom, $urandom});
  endfunction

  initial begin
    void'($urandom(32'h6f8fed7f));
    foreach (exp_mem[i]) exp_mem[i] = '0;
    wide = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (12) @(posedge link_clk);
    apb(1'b0, `DBW_CTRL_OFS, 32'h0);
    check(36'(rd), 36'(`DBW_CTRL_RST), "control reset");
    apb(1'b0, 12'h008, 32'h0);
    check({rd, 3'b000, err}, 36'h1, "unmapped read");
    apb(1'b1, 12'h00C, 32'h0000_0003);
    check(36'(err), 36'h1, "unmapped write");
    apb(1'b0, `DBW_CTRL_OFS, 32'h0);
    check(36'(rd), 36'(`DBW_CTRL_RST), "control after unmapped write");
    burst_chk(1'b0, 4'h2, '1, '1, '0, '0, 1'b0);
    apb(1'b1, `DBW_CTRL_OFS, 32'h3);
    wide = 1'b1;
    apb(1'b0, `DBW_CTRL_OFS, 32'h0);
    check(36'(rd), 36'h3, "control readback");
    repeat (6) @(posedge link_clk);
    foreach (corner[i])
      burst_chk(1'b0, 4'($urandom), rw36(), rw36(), corner[i], corner[7-i], 1'b1);
    for (int i = 0; i < 24; i++)
      burst_chk(1'b0, 4'($urandom), rw36(), rw36(), 4'($urandom), 4'($urandom), 1'b1);
    burst_chk(1'b1, 4'h5, '1, '1, '0, '0, 1'b1);
    apb(1'b1, `DBW_CTRL_OFS, 32'h1);
    wide = 1'b0;
    repeat (6) @(posedge link_clk);
    for (int i = 0; i < 16; i++)
      burst_chk(1'b0, 4'($urandom), rw36(), rw36(), dbw_sel_t'({$urandom, i[1:0]}),
                dbw_sel_t'({$urandom, 2'(3 - i)}), 1'b1);
    // A write issued while the clock enable is low must leave the array and the count alone.
    @(posedge pclk);
    ce <= 1'b0;
    repeat (4) @(posedge link_clk);
    ctl.burst(1'b0, 4'h6, rw36(), rw36(), '0, '0);
    @(posedge pclk);
    ce <= 1'b1;
    repeat (4) @(posedge link_clk);
    peek_chk(4'h6);
    peek_chk(4'h7);
    repeat (10) @(posedge link_clk);
    apb(1'b0, `DBW_STAT_OFS, 32'h0);
    check(36'(rd), 36'(wcount % 256), "write count");
    wrap_up();
  end
endmodule
